/* File: verilog/eeac_pkg.sv */
// Constants shared by the EEPROM access control block
`default_nettype none
package eeac_pkg;
  // Clock rates and write timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned OSC_HZ        = 1_000_000;
  localparam int unsigned OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int unsigned WRITE_OSC_CYC = 8448;
  localparam real         WRITE_TIME_MS = 8.4;
  localparam int unsigned DIV_W         = 5;
  localparam int unsigned TICK_W        = 14;
  // APB register offsets (byte addresses)
  localparam int unsigned APB_AW        = 8;
  localparam logic [7:0]  OFF_ADDR_LO   = 8'h00;
  localparam logic [7:0]  OFF_ADDR_HI   = 8'h04;
  localparam logic [7:0]  OFF_DATA      = 8'h08;
  localparam logic [7:0]  OFF_CTRL      = 8'h0C;
  localparam logic [7:0]  OFF_STAT      = 8'h10;
  localparam logic [7:0]  OFF_MASK      = 8'h14;
  // Cell array geometry
  localparam int unsigned CELL_AW       = 11;
  localparam int unsigned CELL_N        = 2048;
  localparam int unsigned HI_W          = CELL_AW - 8;
  localparam logic [7:0]  ADDR_RST      = 8'h00;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  // Control bit positions
  localparam int unsigned CTRL_RD       = 0;
  localparam int unsigned CTRL_WS       = 1;
  localparam int unsigned CTRL_ARM      = 2;
  // Event bit positions
  localparam int unsigned EV_WDONE      = 0;
  localparam int unsigned EV_RDONE      = 1;
  localparam int unsigned EV_REFUSED    = 2;
  localparam int unsigned EV_N          = 3;
  // Stall and arm windows in processor clocks
  localparam logic [2:0]  READ_STALL    = 3'h4;
  localparam logic [2:0]  WRITE_STALL   = 3'h2;
  localparam logic [2:0]  ARM_HOLD      = 3'h4;
  // Write timer states
  typedef enum logic {T_IDLE = 1'b0, T_RUN = 1'b1} eeac_tstate_t;
endpackage
`default_nettype wire

/* File: verilog/eeac_tmr_if.sv */
// Handshake between access control and write timer
`timescale 1ns/10ps
`default_nettype none
interface eeac_tmr_if;
  logic start;  // One-cycle write launch
  logic done;   // One-cycle end of write
  logic busy;   // Write cycle in progress
  modport ctrl (output start, input done, input busy);
  modport tmr  (input start, output done, output busy);
endinterface
`default_nettype wire

/* File: verilog/eeac_wtimer.sv */
// Write duration timer clocked from a derived 1 MHz tick
`timescale 1ns/10ps
`default_nettype none
module eeac_wtimer
#(
  parameter int unsigned TICKS = eeac_pkg::WRITE_OSC_CYC
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Launch and completion
  eeac_tmr_if.tmr  tif
);
  localparam logic [eeac_pkg::DIV_W-1:0]  DIV_LAST =
    eeac_pkg::DIV_W'(eeac_pkg::OSC_DIV - 1);
  localparam logic [eeac_pkg::TICK_W-1:0] TICK_LAST =
    eeac_pkg::TICK_W'(TICKS - 1);
  localparam logic [31:0] RUN_LAST = 32'(TICKS * eeac_pkg::OSC_DIV - 1);

  eeac_pkg::eeac_tstate_t           state;     // Idle or timing
  logic [eeac_pkg::DIV_W-1:0]       div_cnt;   // Clocks within a tick
  logic [eeac_pkg::TICK_W-1:0]      tick_cnt;  // Oscillator ticks seen
  logic                             last;      // Final clock of write
  logic [31:0]                      run_len;   // Helper for checks

  assign last = (div_cnt == DIV_LAST) && (tick_cnt == TICK_LAST);
  assign tif.busy = (state == eeac_pkg::T_RUN);

  // The 1 MHz tick restarts with each write so every write lasts the same
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= eeac_pkg::T_IDLE;
      div_cnt  <= '0;
      tick_cnt <= '0;
    end
    else
    begin
      case (state)
        eeac_pkg::T_IDLE:
        begin
          div_cnt  <= '0;
          tick_cnt <= '0;
          if (tif.start)
            state <= eeac_pkg::T_RUN;
        end
        eeac_pkg::T_RUN:
        begin
          if (div_cnt == DIV_LAST)
          begin
            div_cnt <= '0;
            if (tick_cnt == TICK_LAST)
              state <= eeac_pkg::T_IDLE;
            else
              tick_cnt <= tick_cnt + eeac_pkg::TICK_W'(1);
          end
          else
            div_cnt <= div_cnt + eeac_pkg::DIV_W'(1);
        end
        default: state <= eeac_pkg::T_IDLE;
      endcase
    end
  end

  // Completion pulse in the first idle cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tif.done <= 1'b0;
    else
      tif.done <= tif.busy && last;
  end

  // Helper: length of the current busy stretch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_len <= '0;
    else if (tif.busy)
      run_len <= run_len + 32'h1;
    else
      run_len <= '0;
  end

  AST_WRITE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(tif.busy) |-> $past(run_len) == RUN_LAST)
    else $error("write duration is not the oscillator count");
  AST_DONE_END: assert property (@(posedge pclk) disable iff (!presetn)
    tif.done |-> !tif.busy && $past(tif.busy))
    else $error("done pulse not at the end of a write");
endmodule
`default_nettype wire

/* File: verilog/eeac_top.sv */
// EEPROM cell access control with APB registers and a write timer
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Read strobe starts read of loaded address
// - Read byte lands in data register immediately
// - Read stalls the processor four cycles
// - Busy write ignores reads and address writes
// - Write lasts 8448 oscillator cycles
// - Write timed by derived 1 MHz tick
// - Arm clears after four; strobe needs arm
// - Write strobe clears when write completes
// - Write strobe stalls the processor two cycles
// - Eleven-bit address across high and low
module eeac_top
#(
  parameter int unsigned WRITE_OSC_CYCLES = eeac_pkg::WRITE_OSC_CYC
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Interrupt and processor hold
  output var  logic        irq,
  output var  logic        cpu_stall
);
  localparam int unsigned HW = eeac_pkg::HI_W;
  localparam int unsigned AW = eeac_pkg::CELL_AW;

  eeac_tmr_if                     tif ();      // Timer handshake
  logic [7:0]                     cell_address_low;
  logic [HW-1:0]                  cell_address_high;
  logic [7:0]                     cell_data_reg;
  logic [AW-1:0]                  cell_address_reg;
  logic [7:0]                     cells [eeac_pkg::CELL_N];
  logic [AW-1:0]                  wr_addr;     // Address latched at launch
  logic [7:0]                     wr_data;     // Data latched at launch
  logic                           write_arm_bit;
  logic [2:0]                     arm_cnt;     // Arm window left
  logic                           read_strobe_bit;
  logic [2:0]                     stall_cnt;   // Hold cycles left
  logic [2:0]                     next_stall;
  logic [eeac_pkg::EV_N-1:0]      status;      // Sticky events
  logic [eeac_pkg::EV_N-1:0]      mask;        // Interrupt enables
  logic [eeac_pkg::EV_N-1:0]      ev_set;
  logic [eeac_pkg::EV_N-1:0]      next_status;
  logic                           acc;         // Completing transfer
  logic                           wr_ctl;
  logic                           rd_go;
  logic                           rd_refused;
  logic                           wr_go;
  logic                           mapped;
  logic [31:0]                    rd_mux;
  logic [7:0]                     rd_byte;     // Cell at current address

  // Bus decode; writes act only at the edge that completes the transfer
  assign acc    = psel && penable && pready;
  assign wr_ctl = acc && pwrite && (paddr == eeac_pkg::OFF_CTRL);
  assign cell_address_reg = {cell_address_high, cell_address_low};
  // A read in the commit cycle sees the byte being written, not the old one
  assign rd_byte = (tif.done && (wr_addr == cell_address_reg)) ? wr_data
                   : cells[cell_address_reg];
  // Reads are dropped, not queued, while a write runs
  assign rd_go      = wr_ctl && pwdata[eeac_pkg::CTRL_RD] && !tif.busy;
  assign rd_refused = wr_ctl && pwdata[eeac_pkg::CTRL_RD] && tif.busy;
  // Launch needs the arm window still open from an earlier write
  assign wr_go = wr_ctl && pwdata[eeac_pkg::CTRL_WS] && write_arm_bit
                 && !tif.busy;
  assign tif.start = wr_go;

  eeac_wtimer #(
    .TICKS (WRITE_OSC_CYCLES)
  ) u_wtimer (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif)
  );

  // Address registers; frozen while a write is in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_address_low  <= eeac_pkg::ADDR_RST;
      cell_address_high <= eeac_pkg::ADDR_RST[HW-1:0];
    end
    else if (acc && pwrite && !tif.busy)
    begin
      if (paddr == eeac_pkg::OFF_ADDR_LO)
        cell_address_low <= pwdata[7:0];
      else if (paddr == eeac_pkg::OFF_ADDR_HI)
        cell_address_high <= pwdata[HW-1:0];
    end
  end

  // Data register: software writes, or the fetched byte on a read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cell_data_reg <= eeac_pkg::DATA_RST;
    else if (rd_go)
      cell_data_reg <= rd_byte;
    else if (acc && pwrite && (paddr == eeac_pkg::OFF_DATA))
      cell_data_reg <= pwdata[7:0];
  end

  // Launch latch keeps the target stable even if data is rewritten
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_addr <= '0;
      wr_data <= '0;
    end
    else if (wr_go)
    begin
      wr_addr <= cell_address_reg;
      wr_data <= cell_data_reg;
    end
  end

  // Cell array commits at the end of the timed write; not reset
  always_ff @(posedge pclk)
  begin
    if (tif.done)
      cells[wr_addr] <= wr_data;
  end

  // Arm bit: opens a window of four clocks, then closes by itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_arm_bit <= 1'b0;
      arm_cnt       <= '0;
    end
    else if (wr_ctl && pwdata[eeac_pkg::CTRL_ARM])
    begin
      write_arm_bit <= 1'b1;
      arm_cnt       <= eeac_pkg::ARM_HOLD;
    end
    else if (arm_cnt == 3'h1)
    begin
      write_arm_bit <= 1'b0;
      arm_cnt       <= '0;
    end
    else if (arm_cnt != '0)
      arm_cnt <= arm_cnt - 3'h1;
  end

  // Read strobe shows for one cycle and then drops back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_strobe_bit <= 1'b0;
    else
      read_strobe_bit <= rd_go;
  end

  // Stall count: a new read or write reloads, else count down
  always_comb
  begin
    if (rd_go)
      next_stall = eeac_pkg::READ_STALL;
    else if (wr_go)
      next_stall = eeac_pkg::WRITE_STALL;
    else if (stall_cnt != '0)
      next_stall = stall_cnt - 3'h1;
    else
      next_stall = '0;
  end

  // Hold output; also stretches the next bus answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stall_cnt <= '0;
      cpu_stall <= 1'b0;
    end
    else
    begin
      stall_cnt <= next_stall;
      cpu_stall <= (next_stall != '0);
    end
  end

  // Events; a set in the clearing cycle wins over the clear
  always_comb
  begin
    ev_set = '0;
    ev_set[eeac_pkg::EV_WDONE]   = tif.done;
    ev_set[eeac_pkg::EV_RDONE]   = rd_go;
    ev_set[eeac_pkg::EV_REFUSED] = rd_refused;
    next_status = status;
    if (acc && pwrite && (paddr == eeac_pkg::OFF_STAT))
      next_status = status & ~pwdata[eeac_pkg::EV_N-1:0];
    next_status = next_status | ev_set;
  end

  // Status, mask and level interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      if (acc && pwrite && (paddr == eeac_pkg::OFF_MASK))
        mask <= pwdata[eeac_pkg::EV_N-1:0];
      irq <= |(next_status & mask);
    end
  end

  // Read mux; unused bits read as zero
  always_comb
  begin
    rd_mux = '0;
    mapped = 1'b1;
    if (paddr == eeac_pkg::OFF_ADDR_LO)
      rd_mux[7:0] = cell_address_low;
    else if (paddr == eeac_pkg::OFF_ADDR_HI)
      rd_mux[HW-1:0] = cell_address_high;
    else if (paddr == eeac_pkg::OFF_DATA)
      rd_mux[7:0] = cell_data_reg;
    else if (paddr == eeac_pkg::OFF_CTRL)
    begin
      rd_mux[eeac_pkg::CTRL_RD]  = read_strobe_bit;
      rd_mux[eeac_pkg::CTRL_WS]  = tif.busy;
      rd_mux[eeac_pkg::CTRL_ARM] = write_arm_bit;
    end
    else if (paddr == eeac_pkg::OFF_STAT)
      rd_mux[eeac_pkg::EV_N-1:0] = status;
    else if (paddr == eeac_pkg::OFF_MASK)
      rd_mux[eeac_pkg::EV_N-1:0] = mask;
    else
      mapped = 1'b0;
  end

  // APB answer: one wait state, more while the processor is held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready && (stall_cnt == '0))
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0 : rd_mux;
      pslverr <= !mapped;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READ_FETCH: assert property (
    rd_go |=> cell_data_reg == $past(rd_byte))
    else $error("read byte not in data register");
  AST_READ_STALL: assert property (
    rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall is not four cycles");
  AST_WRITE_STALL: assert property (
    wr_go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall is not two cycles");
  AST_ADDR_FROZEN: assert property (
    acc && pwrite && tif.busy |=> $stable(cell_address_reg))
    else $error("address changed during a write");
  AST_READ_REFUSED: assert property (
    rd_refused |=> $stable(cell_data_reg) && !read_strobe_bit)
    else $error("refused read touched data or strobe");
  AST_ARM_WINDOW: assert property (
    $rose(write_arm_bit) |-> write_arm_bit [*4] ##1 !write_arm_bit)
    else $error("arm window is not four cycles");
  AST_NO_ARM: assert property (
    wr_ctl && pwdata[eeac_pkg::CTRL_WS] && !write_arm_bit && !tif.busy
    |=> !tif.busy)
    else $error("write launched without arm");
  AST_READ_LAUNCH: assert property (
    wr_ctl && pwdata[eeac_pkg::CTRL_RD] && !tif.busy
    |=> read_strobe_bit ##1 !read_strobe_bit)
    else $error("read strobe not a single cycle");
  AST_WS_SET: assert property (
    wr_go |=> tif.busy ##1 tif.busy)
    else $error("write strobe not held after launch");

  COV_READ:    cover property (rd_go ##[1:20] acc && !pwrite);
  COV_WRITE:   cover property (wr_go);
  COV_REFUSED: cover property (rd_refused);
  COV_IRQ:     cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the EEPROM access control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Short write so one write takes OSC * 20 clocks
  localparam int unsigned OSC  = 4;
  localparam logic [7:0]  A_LO = eeac_pkg::OFF_ADDR_LO;
  localparam logic [7:0]  A_HI = eeac_pkg::OFF_ADDR_HI;
  localparam logic [7:0]  A_DT = eeac_pkg::OFF_DATA;
  localparam logic [7:0]  A_CT = eeac_pkg::OFF_CTRL;
  localparam logic [7:0]  A_ST = eeac_pkg::OFF_STAT;
  localparam logic [7:0]  A_MK = eeac_pkg::OFF_MASK;
  localparam logic [31:0] RD   = 32'h1 << eeac_pkg::CTRL_RD;
  localparam logic [31:0] WS   = 32'h1 << eeac_pkg::CTRL_WS;
  localparam logic [31:0] ARM  = 32'h1 << eeac_pkg::CTRL_ARM;
  localparam logic [31:0] B8   = 32'h0000_00FF;

  // Design ports
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        cpu_stall;
  // Bench state
  int          errors;
  int          n_checks;
  logic [31:0] rv;
  logic        ev;

  eeac_top #(.WRITE_OSC_CYCLES(OSC)) eeac_top_i
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .irq       (irq),
    .cpu_stall (cpu_stall)
  );

  // 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // Single ending point of the run
  task automatic give_verdict();
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer; psel stays up so transfers may follow back to back
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      errors++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, ev);
  endtask

  // Read a register and compare the masked value
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0, rv, ev);
    chk(nm, rv & m, e);
  endtask

  // Bus idle for a number of clocks
  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  // Length of the processor hold window, bus kept idle meanwhile
  task automatic stall_len(input int e);
    int k;
    k = 0;
    psel <= 1'b0;
    repeat (12)
    begin
      @(posedge pclk);
      if (cpu_stall === 1'b1)
        k++;
    end
    chk("stall_cycles", 32'(k), 32'(e));
  endtask

  // Poll the write strobe until it drops, bounded
  task automatic wait_done();
    int n;
    n = 0;
    rv = WS;
    while ((rv & WS) !== 32'h0 && n < 100)
    begin
      apb(1'b0, A_CT, 32'h0, rv, ev);
      n++;
    end
    if ((rv & WS) !== 32'h0)
    begin
      errors++;
      give_verdict();
    end
  endtask

  // Software write sequence: address, data, arm, strobe; no self
  // programming runs beside this bench, so the strobe poll is the only wait
  task automatic do_write(input logic [10:0] a, input logic [7:0] d);
    wait_done();
    wr(A_HI, 32'(a[10:8]));
    wr(A_LO, 32'(a[7:0]));
    wr(A_DT, 32'(d));
    wr(A_CT, ARM);
    wr(A_CT, WS);
    stall_len(2);
  endtask

  // Software read sequence with hold and strobe checks
  task automatic do_read(input logic [10:0] a, input logic [7:0] d);
    wait_done();
    wr(A_HI, 32'(a[10:8]));
    wr(A_LO, 32'(a[7:0]));
    wr(A_CT, RD);
    stall_len(4);
    rdc(A_DT, B8, 32'(d), "read_data");
    rdc(A_CT, RD, 32'h0, "read_strobe");
  endtask

  // Reset values and an unmapped address
  task automatic t_reset();
    for (int i = 0; i < 6; i++)
      rdc(8'(4 * i), 32'hFFFF_FFFF, 32'h0, "reset_value");
    apb(1'b0, 8'h18, 32'h0, rv, ev);
    chk("unmapped_err", 32'(ev), 32'h1);
    chk("unmapped_data", rv, 32'h0);
    wr(A_HI, 32'hFF);
    rdc(A_HI, 32'hFFFF_FFFF, 32'h7, "addr_high_width");
  endtask

  // Busy write refuses reads and address changes; no queued read
  task automatic t_busy();
    do_write(11'h534, 8'hA5);
    rdc(A_CT, WS, WS, "busy_strobe");
    wr(A_LO, 32'h00);
    rdc(A_LO, B8, 32'h34, "busy_addr");
    wr(A_DT, 32'h5A);
    wr(A_CT, RD);
    rdc(A_DT, B8, 32'h5A, "refused_data");
    rdc(A_ST, 32'h4, 32'h4, "refused_flag");
    wait_done();
    idle(4);
    rdc(A_DT, B8, 32'h5A, "not_queued");
    rdc(A_ST, 32'h1, 32'h1, "write_done");
  endtask

  // Write duration from the divided tick, then address bits kept apart
  task automatic t_timing();
    do_write(11'h234, 8'hC3);
    idle(50);
    rdc(A_CT, WS, WS, "still_busy");
    idle(30);
    rdc(A_CT, WS, 32'h0, "write_over");
    do_read(11'h534, 8'hA5);
    do_read(11'h234, 8'hC3);
  endtask

  // Strobe without arm, and after the arm window ran out
  task automatic t_noarm();
    wr(A_CT, WS);
    rdc(A_CT, WS, 32'h0, "no_arm");
    wr(A_CT, ARM);
    idle(6);
    wr(A_CT, WS);
    rdc(A_CT, WS, 32'h0, "arm_expired");
  endtask

  // Interrupt raised, cleared and masked
  task automatic t_irq();
    wr(A_ST, 32'h7);
    rdc(A_ST, 32'h7, 32'h0, "status_clear");
    wr(A_MK, 32'h1);
    do_write(11'h7FF, 8'h3C);
    wait_done();
    idle(3);
    chk("irq_set", 32'(irq), 32'h1);
    wr(A_ST, 32'h1);
    idle(3);
    chk("irq_clear", 32'(irq), 32'h0);
    do_read(11'h7FF, 8'h3C);
    idle(3);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(A_MK, 32'h2);
    idle(3);
    chk("irq_unmasked", 32'(irq), 32'h1);
  endtask

  // Main sequence
  initial
  begin
    errors   = 0;
    n_checks = 0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_busy();
    t_timing();
    t_noarm();
    t_irq();
    idle(2);
    give_verdict();
  end
endmodule
`default_nettype wire
